/* hw/wim_top.sv */
// wake input monitor top
`default_nettype none
module wim_top #(
    parameter int unsigned FILTER_CYCLES = wim_pkg::WAKE_FILTER_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // comparator output of wake_input_pin
    input wire logic wake_input_pin,
    // configuration
    input wire logic [4:0] sbc_mode,
    input wire logic pin_wake_enable,
    input wire logic cyclic_sense_enable,
    input wire logic cyclic_window_active,
    input wire logic buck_mode_from_pin,
    input wire logic wake_pull_select_high,
    input wire logic wake_pull_select_low,
    input wire logic clear_pin_wake_source_flag,
    // status and events
    output logic pin_wake_source_flag,
    output logic wake_level_status,
    output logic wake_interrupt_req,
    output logic wake_from_sleep_req,
    output logic restart_req,
    // buck and pull control
    output logic buck_pwm_select,
    output logic pull_up_enable,
    output logic pull_down_enable
);
    // -------------------------------------------------
    // reset release and input synchroniser
    // -------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] pin_sync_reg;
    logic pin_level;
    logic load_reg, load_next;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_reg <= 2'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], wake_input_pin};
        end
    end
    assign pin_level = pin_sync_reg[1];

    // load held until the synchroniser holds a real sample
    logic [1:0] ld_cnt_reg, ld_cnt_next;
    always_comb begin
        ld_cnt_next = ld_cnt_reg;
        load_next = 1'b0;
        if (ld_cnt_reg != 2'h3) begin
            ld_cnt_next = ld_cnt_reg + 2'h1;
            load_next = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_cnt_reg <= 2'h0;
            load_reg <= 1'b1;
        end else begin
            ld_cnt_reg <= ld_cnt_next;
            load_reg <= load_next;
        end
    end

    // -------------------------------------------------
    // filter
    // -------------------------------------------------
    logic sense_active;
    logic filt_level;
    logic filt_changed;
    // cyclic sense: filter runs only inside the window
    assign sense_active = !cyclic_sense_enable
                          || cyclic_window_active;

    wim_filter #(
        .CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .level_in(pin_level),
        .load(load_reg),
        .active(sense_active),
        .level_out(filt_level),
        .changed(filt_changed)
    );

    // -------------------------------------------------
    // event routing
    // -------------------------------------------------
    logic is_active, is_stop, is_sleep, is_fs;
    logic flag_reg, flag_next;
    logic irq_reg, irq_next;
    logic wake_reg, wake_next;
    logic rst_req_reg, rst_req_next;
    logic lvl_reg, lvl_next;
    logic pwm_reg, pwm_next;
    logic pu_reg, pu_next;
    logic pd_reg, pd_next;
    logic [1:0] pull_sel;
    logic wake_ev;

    // normal or stop: modes that interrupt and show the level
    function automatic logic active_mode(input logic [4:0] m);
        return (m == wim_pkg::WIM_MODE_NORMAL)
            || (m == wim_pkg::WIM_MODE_STOP);
    endfunction

    assign is_active = active_mode(sbc_mode);
    assign is_stop = sbc_mode == wim_pkg::WIM_MODE_STOP;
    assign is_sleep = sbc_mode == wim_pkg::WIM_MODE_SLEEP;
    assign is_fs = sbc_mode == wim_pkg::WIM_MODE_FAIL_SAFE;
    assign pull_sel = {wake_pull_select_high, wake_pull_select_low};
    assign wake_ev = filt_changed && pin_wake_enable;

    always_comb begin
        irq_next = wake_ev && is_active;
        wake_next = wake_ev && is_sleep;
        rst_req_next = filt_changed && is_fs;
        flag_next = flag_reg;
        if (clear_pin_wake_source_flag) begin
            flag_next = 1'b0;
        end
        if (wake_ev || (filt_changed && is_fs)) begin
            flag_next = 1'b1;
        end
        lvl_next = lvl_reg;
        if (is_active) begin
            lvl_next = filt_level;
        end
        pwm_next = pwm_reg;
        if (buck_mode_from_pin && is_stop) begin
            pwm_next = pin_level;
        end else if (!buck_mode_from_pin) begin
            pwm_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            rst_req_reg <= 1'b0;
            lvl_reg <= 1'b0;
            pwm_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            rst_req_reg <= rst_req_next;
            lvl_reg <= lvl_next;
            pwm_reg <= pwm_next;
        end
    end

    // -------------------------------------------------
    // pull current control
    // -------------------------------------------------
    // auto follows the filtered level, so a bounce never flips it
    always_comb begin
        case (pull_sel)
            wim_pkg::PULL_NONE: begin
                pu_next = 1'b0;
                pd_next = 1'b0;
            end
            wim_pkg::PULL_DOWN: begin
                pu_next = 1'b0;
                pd_next = 1'b1;
            end
            wim_pkg::PULL_UP: begin
                pu_next = 1'b1;
                pd_next = 1'b0;
            end
            wim_pkg::PULL_AUTO: begin
                pu_next = filt_level;
                pd_next = !filt_level;
            end
            default: begin
                pu_next = 1'b0;
                pd_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            pu_reg <= pu_next;
            pd_reg <= pd_next;
        end
    end

    // -------------------------------------------------
    // status outputs
    // -------------------------------------------------
    assign pin_wake_source_flag = flag_reg;
    assign wake_level_status = lvl_reg;
    assign wake_interrupt_req = irq_reg;
    assign wake_from_sleep_req = wake_reg;
    assign restart_req = rst_req_reg;
    assign buck_pwm_select = pwm_reg;
    assign pull_up_enable = pu_reg;
    assign pull_down_enable = pd_reg;
endmodule // wim_top
`default_nettype wire

/* hw/wim_pkg.sv */
// constants and types for the wake input monitor
`default_nettype none
package wim_pkg;
    // -------------------------------------------------
    // timing
    // -------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 100;
    localparam int unsigned WAKE_FILTER_TIME_US = 16;
    localparam int unsigned WAKE_FILTER_CYCLES =
        WAKE_FILTER_TIME_US * CLK_FREQ_MHZ;
    // -------------------------------------------------
    // modes and pull field
    // -------------------------------------------------
    typedef enum logic [4:0] {
        WIM_MODE_NORMAL    = 5'h01,
        WIM_MODE_STOP      = 5'h02,
        WIM_MODE_SLEEP     = 5'h04,
        WIM_MODE_FAIL_SAFE = 5'h08,
        WIM_MODE_OTHER     = 5'h10
    } wim_mode_e;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;
    localparam logic [1:0] PULL_RESET = PULL_NONE;
    localparam int unsigned PULL_SEL_HIGH_BIT = 1;
    localparam int unsigned PULL_SEL_LOW_BIT = 0;
endpackage : wim_pkg
`default_nettype wire

/* hw/wim_filter.sv */
// stability filter for the synchronised wake level
`default_nettype none
module wim_filter #(
    parameter int unsigned CYCLES = wim_pkg::WAKE_FILTER_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in
    input wire logic level_in,
    input wire logic load,
    input wire logic active,
    // filtered out
    output logic level_out,
    output logic changed
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic level_reg, level_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic chg_reg, chg_next;

    always_comb begin
        level_next = level_reg;
        cnt_next = '0;
        chg_next = 1'b0;
        if (load) begin
            level_next = level_in;
        end else if (active && (level_in != level_reg)) begin
            if (cnt_reg == CW'(CYCLES - 1)) begin
                level_next = level_in;
                chg_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= 1'b0;
            cnt_reg <= '0;
            chg_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            cnt_reg <= cnt_next;
            chg_reg <= chg_next;
        end
    end

    assign level_out = level_reg;
    assign changed = chg_reg;
endmodule // wim_filter
`default_nettype wire

/* test/wim_top_props.sv */
// assertions on the wake input monitor top ports
`default_nettype none
module wim_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // controls
    input wire logic [4:0] sbc_mode,
    input wire logic pin_wake_enable,
    input wire logic buck_mode_from_pin,
    input wire logic wake_pull_select_high,
    input wire logic wake_pull_select_low,
    // results
    input wire logic pin_wake_source_flag,
    input wire logic wake_interrupt_req,
    input wire logic wake_from_sleep_req,
    input wire logic restart_req,
    input wire logic buck_pwm_select,
    input wire logic pull_up_enable,
    input wire logic pull_down_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    one_event_a: assert property (
        $onehot0({wake_interrupt_req, wake_from_sleep_req, restart_req}))
        else $error("two events at once");
    irq_mode_a: assert property (
        wake_interrupt_req |-> $past(pin_wake_enable) && ($past(sbc_mode)
        inside {wim_pkg::WIM_MODE_NORMAL, wim_pkg::WIM_MODE_STOP}))
        else $error("interrupt in wrong mode");
    sleep_wake_a: assert property (wake_from_sleep_req |->
        $past(pin_wake_enable) && $past(sbc_mode) == wim_pkg::WIM_MODE_SLEEP)
        else $error("sleep wake in wrong mode");
    restart_mode_a: assert property (
        restart_req |-> $past(sbc_mode) == wim_pkg::WIM_MODE_FAIL_SAFE)
        else $error("restart outside fail-safe");
    irq_pulse_a: assert property (
        wake_interrupt_req |=> !wake_interrupt_req)
        else $error("interrupt longer than one cycle");
    flag_set_a: assert property (
        wake_interrupt_req || wake_from_sleep_req || restart_req
        |-> ##[0:1] pin_wake_source_flag) else $error("flag not set");
    pull_down_a: assert property (
        (!wake_pull_select_high && wake_pull_select_low)[*3]
        |-> pull_down_enable && !pull_up_enable) else $error("pull wrong");
    buck_pfm_a: assert property (
        !buck_mode_from_pin[*2] |-> !buck_pwm_select)
        else $error("pwm without pin select");
endmodule // wim_top_props
bind wim_top wim_top_props u_props (.clk(clk), .arst_n(arst_n),
    .sbc_mode(sbc_mode), .pin_wake_enable(pin_wake_enable),
    .buck_mode_from_pin(buck_mode_from_pin),
    .wake_pull_select_high(wake_pull_select_high),
    .wake_pull_select_low(wake_pull_select_low),
    .pin_wake_source_flag(pin_wake_source_flag),
    .wake_interrupt_req(wake_interrupt_req),
    .wake_from_sleep_req(wake_from_sleep_req), .restart_req(restart_req),
    .buck_pwm_select(buck_pwm_select), .pull_up_enable(pull_up_enable),
    .pull_down_enable(pull_down_enable));
`default_nettype wire

/* test/wim_wake_src.sv */
// model of the switch driving the wake input pin
`default_nettype none
module wim_wake_src (
    // clock
    input wire logic clk,
    // pin
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'h0;
    task automatic set_level(input logic v);
        pin = v;
    endtask
    // short bounce that the filter must drop
    task automatic glitch(input int n);
        pin = ~pin;
        repeat (n) @(posedge clk);
        #1 pin = ~pin;
    endtask
endmodule // wim_wake_src
`default_nettype wire

/* test/wim_top_tb_top.sv */
// self-checking bench for the wake input monitor
`default_nettype none
module wim_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned N = 8;
    logic clk = 1'h0, arst_n = 1'h0, en = 1'h1, cyc = 1'h0, win = 1'h0;
    logic bmp = 1'h0, clr = 1'h0, lvl = 1'h0, pin;
    logic [4:0] mode = wim_pkg::WIM_MODE_NORMAL;
    logic [1:0] pull = 2'h0;
    logic flag, lvl_st, irq, slp, rst_rq, pwm, pu, pd;
    logic [2:0] seen;
    logic [4:0] m_tab [3] = '{wim_pkg::WIM_MODE_SLEEP,
        wim_pkg::WIM_MODE_STOP, wim_pkg::WIM_MODE_FAIL_SAFE};
    logic [2:0] e_tab [3] = '{3'h2, 3'h1, 3'h4};
    int n_fail = 0, checked = 0, cycles = 0;
    always #5 clk = ~clk;
    wim_wake_src src (.clk(clk), .pin(pin));
    wim_top #(.FILTER_CYCLES(N)) uut (.clk(clk), .arst_n(arst_n),
        .wake_input_pin(pin), .sbc_mode(mode), .pin_wake_enable(en),
        .cyclic_sense_enable(cyc), .cyclic_window_active(win),
        .buck_mode_from_pin(bmp), .wake_pull_select_high(pull[1]),
        .wake_pull_select_low(pull[0]), .clear_pin_wake_source_flag(clr),
        .pin_wake_source_flag(flag), .wake_level_status(lvl_st),
        .wake_interrupt_req(irq), .wake_from_sleep_req(slp),
        .restart_req(rst_rq), .buck_pwm_select(pwm),
        .pull_up_enable(pu), .pull_down_enable(pd));
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [2:0] s,
        input logic [2:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, s);
        end
    endtask
    // gather event pulses over the answer window
    task automatic watch();
        seen = 3'h0;
        repeat (2 * N) begin
            @(posedge clk);
            #1 seen = seen | {rst_rq, slp, irq};
        end
    endtask
    task automatic toggle(input logic v);
        lvl = v;
        src.set_level(v);
        watch();
    endtask
    task automatic clear_flag();
        clr = 1'h1;
        @(posedge clk);
        #1 clr = 1'h0;
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 arst_n = 1'h1;
        repeat (10) @(posedge clk);
        #1 toggle(1'h1);
        check("rise", seen, 3'h1);
        check("flag", {2'h0, flag}, 3'h1);
        check("level", {2'h0, lvl_st}, 3'h1);
        clear_flag();
        check("cleared", {2'h0, flag}, 3'h0);
        toggle(1'h0);
        check("fall", seen, 3'h1);
        check("level", {2'h0, lvl_st}, 3'h0);
        src.glitch(N / 2);
        watch();
        check("glitch", seen, 3'h0);
        $display("test edges done");
        clear_flag();
        en = 1'h0;
        toggle(1'h1);
        check("disabled", seen, 3'h0);
        check("no flag", {2'h0, flag}, 3'h0);
        for (int i = 0; i < 3; i++) begin
            mode = m_tab[i];
            en = (i != 2);
            toggle(~lvl);
            check("mode", seen, e_tab[i]);
            if (i == 0) check("held", {2'h0, lvl_st}, 3'h1);
        end
        $display("test modes done");
        mode = wim_pkg::WIM_MODE_NORMAL;
        en = 1'h1;
        cyc = 1'h1;
        toggle(1'h1);
        check("closed", seen, 3'h0);
        win = 1'h1;
        watch();
        check("open", seen, 3'h1);
        cyc = 1'h0;
        for (int c = 0; c < 4; c++) begin
            pull = 2'(c);
            repeat (3) @(posedge clk);
            #1 check("pull", {1'h0, pu, pd}, {1'h0, c > 1, c == 1 || c == 3 &&
                !lvl});
        end
        toggle(1'h0);
        check("auto", {1'h0, pu, pd}, 3'h1);
        $display("test sense and pull done");
        mode = wim_pkg::WIM_MODE_STOP;
        bmp = 1'h1;
        src.set_level(1'h1);
        repeat (4) @(posedge clk);
        #1 check("pwm", {2'h0, pwm}, 3'h1);
        src.set_level(1'h0);
        watch();
        check("unfiltered", seen, 3'h0);
        check("pfm", {2'h0, pwm}, 3'h0);
        $display("test buck done");
        print_verdict();
    end
endmodule // wim_top_tb_top
`default_nettype wire
